// ==== adc_i2c_result_config_port.sv ====
// Functional notes
// - NACK address while conversion runs.
// - ACK address once conversion completed.
// - Sleep after conversion, holding result.
// - Read makes device transmitter, three bytes.
// - After three bytes: empty, convert, refuse.
// - Shift result MSB first on SCL falls.
// - Bit 23 high for positive, low for negative.
// - Overrange: bits 23,22 high, sixteen zeros.
// - Underrange: bits 23,22 low, sixteen ones.
// - Seventeen bits carry two's complement value.
// - Last six bits read back configuration.
// - Clamp to full scale plus/minus LSB.
// - Zero code may report either polarity.
// - Input select routes conversion to temperature.
// - Temperature forces gain one, normal speed.
// - Three gain bits select eight gains.
// - Two bits select line rejection notch.
// - Normal speed calibrates; double rate skips it.
// - Result settles within one conversion cycle.
// - Only result and configuration registers exist.
// - Stop after an acknowledged address, or 24 bits read, starts conversion.
// - Configuration defaults after power-up.
// - Global address write plus stop starts conversion.
`timescale 1ns/1ps
module adc_i2c_result_config_port (
  input wire logic clk,
  input wire logic resetn,
  input wire logic scl,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] dev_addr,
  output logic conv_start,
  input wire logic conv_done,
  input wire logic signed [17:0] conv_sample,
  input wire logic conv_zero_polarity,
  output logic busy,
  output logic sleep,
  output logic temp_sensor_on,
  output logic [2:0] gain_code,
  output logic [8:0] gain_factor,
  output logic [1:0] reject_sel,
  output logic double_rate_on,
  output logic calibration_on,
  output logic [23:0] result_word
);
  typedef enum logic [2:0] {
    ST_IDLE, ST_ADDR, ST_ACK, ST_RX, ST_TX, ST_MACK, ST_IGNORE
  } bus_state_t;

  // ****************************************
  // Gain decode.
  // ****************************************
  function automatic logic [8:0] gain_of(input logic [2:0] code,
                                         input logic dbl);
    logic [8:0] g;
    g = 9'h001;
    if (dbl) begin
      g = 9'h001 << code;
    end else if (code != 3'h0) begin
      g = 9'h001 << (4'(code) + 4'h1);
    end
    return g;
  endfunction

  bus_state_t state_reg;
  logic scl_prev_reg;
  logic sda_prev_reg;
  logic [3:0] bit_cnt_reg;
  logic [1:0] byte_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] tx_shift_reg;
  logic ack_reg;
  logic rw_reg;
  logic master_ack_reg;
  logic io_phase_reg;
  logic converting_reg;
  logic drive_low_reg;
  logic conv_start_reg;
  logic init_reg;
  logic [adc_i2c_pkg::CFG_W-1:0] pending_cfg_reg;
  logic [adc_i2c_pkg::CFG_W-1:0] active_cfg_reg;

  // ****************************************
  // Bus condition decode.
  // ****************************************
  wire scl_rise = scl & ~scl_prev_reg;
  wire scl_fall = ~scl & scl_prev_reg;
  wire start_cond = scl & scl_prev_reg & sda_prev_reg & ~sda_in;
  wire stop_cond = scl & scl_prev_reg & ~sda_prev_reg & sda_in;
  wire [6:0] rx_addr = shift_reg[7:1];
  wire rx_rw = shift_reg[0];
  wire addr_hit = (rx_addr == dev_addr) ||
    (rx_addr == adc_i2c_pkg::GLOBAL_ADDR && !rx_rw);
  wire byte_end = scl_fall && bit_cnt_reg == adc_i2c_pkg::BYTE_BITS;
  wire [7:0] tx_byte = byte_cnt_reg == 2'h0 ? result_word[23:16] :
    byte_cnt_reg == 2'h1 ? result_word[15:8] : result_word[7:0];
  wire result_load = conv_done && converting_reg;
  wire read_done = byte_cnt_reg == adc_i2c_pkg::READ_BYTES;

  // ****************************************
  // Mode outputs from the active configuration, then bus and status outputs.
  // ****************************************
  wire im_bit = active_cfg_reg[adc_i2c_pkg::CFG_IM_POS];
  wire [2:0] gs_bits =
    active_cfg_reg[adc_i2c_pkg::CFG_GS_MSB:adc_i2c_pkg::CFG_GS_LSB];
  assign temp_sensor_on = im_bit;
  assign gain_code = im_bit ? 3'h0 : gs_bits;
  assign double_rate_on = im_bit ? 1'b0 :
    active_cfg_reg[adc_i2c_pkg::CFG_SPD_POS];
  assign calibration_on = ~double_rate_on;
  assign gain_factor = gain_of(gain_code, double_rate_on);
  assign reject_sel = {active_cfg_reg[adc_i2c_pkg::CFG_FA_POS],
                       active_cfg_reg[adc_i2c_pkg::CFG_FB_POS]};
  assign sda_out = 1'b0;
  assign sda_oe = drive_low_reg;
  assign conv_start = conv_start_reg;
  assign busy = converting_reg;
  assign sleep = ~converting_reg & ~io_phase_reg;

  // ****************************************
  // Result register.
  // ****************************************
  result_formatter u_fmt (
    .clk(clk),
    .resetn(resetn),
    .load(result_load),
    .sample(conv_sample),
    .zero_polarity(conv_zero_polarity),
    .cfg_snapshot(active_cfg_reg),
    .result_word(result_word)
  );

  always_ff @(posedge clk) begin
    if (!resetn) begin
      scl_prev_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_prev_reg <= scl;
      sda_prev_reg <= sda_in;
    end
  end

  // ****************************************
  // Bus sequencer and conversion control.
  // ****************************************
  always_ff @(posedge clk) begin
    if (!resetn) begin
      state_reg <= ST_IDLE;
      bit_cnt_reg <= 4'h0;
      byte_cnt_reg <= 2'h0;
      shift_reg <= 8'h00;
      tx_shift_reg <= 8'h00;
      ack_reg <= 1'b0;
      rw_reg <= 1'b0;
      master_ack_reg <= 1'b0;
      io_phase_reg <= 1'b0;
      converting_reg <= 1'b0;
      drive_low_reg <= 1'b0;
      conv_start_reg <= 1'b0;
      init_reg <= 1'b1;
      pending_cfg_reg <= adc_i2c_pkg::CFG_RESET;
      active_cfg_reg <= adc_i2c_pkg::CFG_RESET;
    end else begin
      conv_start_reg <= 1'b0;
      init_reg <= 1'b0;
      if (result_load) begin
        converting_reg <= 1'b0;
      end
      if (init_reg) begin
        conv_start_reg <= 1'b1;
        converting_reg <= 1'b1;
      end
      if (start_cond) begin
        state_reg <= ST_ADDR;
        bit_cnt_reg <= 4'h0;
        byte_cnt_reg <= 2'h0;
        drive_low_reg <= 1'b0;
      end else if (stop_cond) begin
        state_reg <= ST_IDLE;
        drive_low_reg <= 1'b0;
        if (io_phase_reg) begin
          io_phase_reg <= 1'b0;
          conv_start_reg <= 1'b1;
          converting_reg <= 1'b1;
          active_cfg_reg <= pending_cfg_reg;
        end
      end else begin
        case (state_reg)
          ST_ADDR, ST_RX: begin
            if (scl_rise) begin
              shift_reg <= {shift_reg[6:0], sda_in};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (byte_end) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == ST_RX) begin
                pending_cfg_reg <= shift_reg[adc_i2c_pkg::CFG_W-1:0];
                ack_reg <= 1'b1;
                drive_low_reg <= 1'b1;
                state_reg <= ST_ACK;
              end else if (!addr_hit) begin
                state_reg <= ST_IGNORE;
              end else begin
                rw_reg <= rx_rw;
                ack_reg <= ~converting_reg;
                drive_low_reg <= ~converting_reg;
                if (!converting_reg) begin
                  io_phase_reg <= 1'b1;
                end
                state_reg <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (!ack_reg) begin
                drive_low_reg <= 1'b0;
                state_reg <= ST_IGNORE;
              end else if (rw_reg) begin
                tx_shift_reg <= tx_byte;
                drive_low_reg <= ~tx_byte[7];
                state_reg <= ST_TX;
              end else begin
                drive_low_reg <= 1'b0;
                state_reg <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (scl_fall) begin
              if (bit_cnt_reg == adc_i2c_pkg::TX_LAST_BIT) begin
                drive_low_reg <= 1'b0;
                byte_cnt_reg <= byte_cnt_reg + 2'h1;
                state_reg <= ST_MACK;
              end else begin
                tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
                drive_low_reg <= ~tx_shift_reg[6];
                bit_cnt_reg <= bit_cnt_reg + 4'h1;
              end
            end
          end
          ST_MACK: begin
            if (scl_rise) begin
              master_ack_reg <= ~sda_in;
            end else if (scl_fall) begin
              bit_cnt_reg <= 4'h0;
              if (read_done) begin
                io_phase_reg <= 1'b0;
                conv_start_reg <= 1'b1;
                converting_reg <= 1'b1;
                active_cfg_reg <= pending_cfg_reg;
                state_reg <= ST_IGNORE;
              end else if (master_ack_reg) begin
                tx_shift_reg <= tx_byte;
                drive_low_reg <= ~tx_byte[7];
                state_reg <= ST_TX;
              end else begin
                state_reg <= ST_IGNORE;
              end
            end
          end
          ST_IDLE, ST_IGNORE: begin
            drive_low_reg <= 1'b0;
          end
          default: begin
            state_reg <= ST_IDLE;
          end
        endcase
      end
    end
  end

  // ****************************************
  // Assertions.
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);

  wire addr_decide = state_reg == ST_ADDR && byte_end && !start_cond &&
    !stop_cond && addr_hit;

  a_nack_while_busy: assert property (
    addr_decide && converting_reg && !result_load |=> !sda_oe [*2])
    else $error("address acknowledged during conversion");
  a_ack_when_ready: assert property (
    addr_decide && !converting_reg |=> sda_oe && !sda_out && ack_reg)
    else $error("ready device did not acknowledge");
  a_read_end_start: assert property (
    state_reg == ST_MACK && scl_fall && read_done && !start_cond &&
    !stop_cond |=> conv_start && busy && state_reg == ST_IGNORE)
    else $error("three byte read did not start conversion");
  a_stop_starts_conv: assert property (
    stop_cond && io_phase_reg && !start_cond |=> conv_start ##1 !conv_start)
    else $error("stop did not start a conversion");
  a_sleep_after_done: assert property (
    result_load && !conv_start_reg && !io_phase_reg && !stop_cond &&
    !(state_reg == ST_MACK) |=> sleep && !busy)
    else $error("no sleep after conversion");
  a_temp_forces_mode: assert property (
    temp_sensor_on |-> gain_factor == 9'h001 && !double_rate_on &&
    calibration_on)
    else $error("temperature input did not force gain and speed");
  a_cfg_deferred: assert property (
    $changed(active_cfg_reg) |-> conv_start)
    else $error("configuration changed outside a conversion start");
  a_tx_bit_order: assert property (
    state_reg == ST_ACK && scl_fall && ack_reg && rw_reg && !start_cond &&
    !stop_cond |=> sda_oe == ~$past(tx_byte[7]))
    else $error("first result bit not driven from bit 23");
  a_over_flags: assert property (
    result_load && conv_sample > adc_i2c_pkg::POS_FS_CODE |=>
    result_word[23:22] == 2'b11 &&
    result_word[21:6] == adc_i2c_pkg::OVER_FILL)
    else $error("overrange word not flagged");
  a_under_flags: assert property (
    result_load && conv_sample < adc_i2c_pkg::NEG_FS_CODE |=>
    result_word[23:22] == 2'b00 &&
    result_word[21:6] == adc_i2c_pkg::UNDER_FILL)
    else $error("underrange word not flagged");
  a_readback_copy: assert property (
    result_load |=> result_word[adc_i2c_pkg::READBACK_W-1:0] ==
    active_cfg_reg[adc_i2c_pkg::READBACK_W-1:0])
    else $error("readback bits differ from configuration");
  a_result_held: assert property (
    !result_load |=> $stable(result_word))
    else $error("result changed without a conversion");
  a_sleep_quiet: assert property (
    sleep |-> !sda_oe)
    else $error("sleeping device drives the data line");

  c_full_read: cover property (
    state_reg == ST_MACK && scl_fall && read_done);
  c_global_write: cover property (
    addr_decide && rx_addr == adc_i2c_pkg::GLOBAL_ADDR && !converting_reg);
  c_nack_busy: cover property (addr_decide && converting_reg);
  c_temp_conv: cover property (result_load && temp_sensor_on);
endmodule

// ==== result_formatter.sv ====
`timescale 1ns/1ps
package adc_i2c_pkg;
  localparam logic [6:0] GLOBAL_ADDR = 7'h77;
  localparam int CFG_W = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 7'h00;
  localparam int CFG_GS_MSB = 6;
  localparam int CFG_GS_LSB = 4;
  localparam int CFG_IM_POS = 3;
  localparam int CFG_FA_POS = 2;
  localparam int CFG_FB_POS = 1;
  localparam int CFG_SPD_POS = 0;
  localparam int READBACK_W = 6;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] TX_LAST_BIT = 4'h7;
  localparam logic [1:0] READ_BYTES = 2'h3;
  localparam logic signed [17:0] POS_FS_CODE = 18'sh0_ffff;
  localparam logic signed [17:0] NEG_FS_CODE = 18'sh3_0000;
  localparam logic [15:0] OVER_FILL = 16'h0000;
  localparam logic [15:0] UNDER_FILL = 16'hffff;
endpackage

module result_formatter (
  input wire logic clk,
  input wire logic resetn,
  input wire logic load,
  input wire logic signed [17:0] sample,
  input wire logic zero_polarity,
  input wire logic [adc_i2c_pkg::CFG_W-1:0] cfg_snapshot,
  output logic [23:0] result_word
);
  // ****************************************
  // Clamp, flag and readback assembly.
  // ****************************************
  wire over = sample > adc_i2c_pkg::POS_FS_CODE;
  wire under = sample < adc_i2c_pkg::NEG_FS_CODE;
  wire is_zero = sample == 18'sh0_0000;
  wire polarity_flag = is_zero ? zero_polarity : ~sample[17];
  wire [adc_i2c_pkg::READBACK_W-1:0] readback =
    cfg_snapshot[adc_i2c_pkg::READBACK_W-1:0];
  wire [23:0] word_next =
    over ? {2'b11, adc_i2c_pkg::OVER_FILL, readback} :
    under ? {2'b00, adc_i2c_pkg::UNDER_FILL, readback} :
    {polarity_flag, sample[16:0], readback};

  always_ff @(posedge clk) begin
    if (!resetn) begin
      result_word <= 24'h00_0000;
    end else if (load) begin
      result_word <= word_next;
    end
  end
endmodule

// ==== i2c_master_model.sv ====
`timescale 1ns/1ps
module i2c_master_model (
  input wire logic clk,
  input wire logic sda_wire,
  output logic scl,
  output logic sda_rel
);
  initial begin
    scl = 1'b1;
    sda_rel = 1'b1;
  end
  // ****************
  // Bus conditions.
  // ****************
  task automatic hold(input int n);
    repeat (n) @(negedge clk);
  endtask
  task automatic clk_bit(input logic b, output logic seen);
    sda_rel = b;
    hold(2);
    scl = 1'b1;
    hold(4);
    seen = sda_wire;
    scl = 1'b0;
    hold(2);
  endtask
  task automatic start();
    sda_rel = 1'b1;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_rel = 1'b0;
    hold(4);
    scl = 1'b0;
    hold(2);
  endtask
  task automatic stop();
    sda_rel = 1'b0;
    hold(2);
    scl = 1'b1;
    hold(4);
    sda_rel = 1'b1;
    hold(4);
  endtask
  // Sends eight bits first bit highest and reports the acknowledge.
  task automatic send(input logic [7:0] v, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(v[i], s);
    clk_bit(1'b1, s);
    ack = ~s;
  endtask
  task automatic recv(input logic ack, output logic [7:0] v);
    logic s;
    for (int i = 7; i >= 0; i--) clk_bit(1'b1, v[i]);
    clk_bit(~ack, s);
  endtask
endmodule

// ==== adc_i2c_result_config_port_tb.sv ====
`timescale 1ns/1ps
module adc_i2c_result_config_port_tb;
  localparam logic [6:0] ADDR = 7'h24;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  logic conv_done = 1'b0;
  logic signed [17:0] conv_sample = 18'sh0_0000;
  logic conv_zero_polarity = 1'b1;
  wire scl, sda_rel, sda_out, sda_oe, conv_start, busy, sleep;
  wire temp_sensor_on, double_rate_on, calibration_on;
  wire [2:0] gain_code;
  wire [8:0] gain_factor;
  wire [1:0] reject_sel;
  wire [23:0] result_word;
  wire sda = sda_rel & (sda_out | ~sda_oe);
  int miscompares = 0;
  int n_compared = 0;
  int cycles = 0;
  int cnt = 0;
  logic ack;
  logic [7:0] b0, b1, b2;
  logic [6:0] cfgs [5] = '{7'h00, 7'h55, 7'h7a, 7'h61, 7'h70};
  logic signed [17:0] smps [5] = '{18'sh0_1234, 18'sh3_fffb,
    18'sh1_0000, 18'sh2_0000, 18'sh0_0000};
  always #12.5 clk = ~clk;
  adc_i2c_result_config_port i_dut (.clk(clk), .resetn(resetn),
    .scl(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .dev_addr(ADDR), .conv_start(conv_start), .conv_done(conv_done),
    .conv_sample(conv_sample), .conv_zero_polarity(conv_zero_polarity),
    .busy(busy), .sleep(sleep), .temp_sensor_on(temp_sensor_on),
    .gain_code(gain_code), .gain_factor(gain_factor),
    .reject_sel(reject_sel), .double_rate_on(double_rate_on),
    .calibration_on(calibration_on), .result_word(result_word));
  i2c_master_model i_master (.clk(clk), .sda_wire(sda), .scl(scl),
    .sda_rel(sda_rel));
  // ****************
  // Converter and checking.
  // ****************
  always @(negedge clk) begin
    conv_done <= (cnt == 1) && !conv_start;
    if (conv_start) cnt <= 400;
    else if (cnt > 0) cnt <= cnt - 1;
  end
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      miscompares++;
      print_verdict();
    end
  end
  task automatic print_verdict();
    $display("Compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic check(input logic [23:0] seen, input logic [23:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [23:0] expw(input logic signed [17:0] s,
    input logic p, input logic [6:0] c);
    if (s > adc_i2c_pkg::POS_FS_CODE) return {2'b11, 16'h0000, c[5:0]};
    if (s < adc_i2c_pkg::NEG_FS_CODE) return {2'b00, 16'hffff, c[5:0]};
    return {(s == 0) ? p : ~s[17], s[16:0], c[5:0]};
  endfunction
  function automatic logic [8:0] expg(input logic [6:0] c);
    if (c[3]) return 9'h001;
    if (c[0]) return 9'h001 << c[6:4];
    return (c[6:4] == 3'h0) ? 9'h001 : 9'h002 << c[6:4];
  endfunction
  task automatic wait_idle();
    repeat (2000) if (busy !== 1'b0) @(negedge clk);
    @(negedge clk);
  endtask
  task automatic read3(input logic [23:0] exp);
    check(result_word, exp);
    i_master.start();
    i_master.send({ADDR, 1'b1}, ack);
    check(24'(ack), 24'h00_0001);
    i_master.recv(1'b1, b0);
    i_master.recv(1'b1, b1);
    i_master.recv(1'b0, b2);
    check({b0, b1, b2}, exp);
  endtask
  // ****************
  // Test sequence.
  // ****************
  initial begin
    repeat (16) @(negedge clk);
    resetn = 1'b1;
    i_master.start();
    i_master.send({ADDR, 1'b1}, ack);
    check(24'(ack), 24'h00_0000);
    i_master.stop();
    wait_idle();
    check(24'(sleep), 24'h00_0001);
    read3(24'h80_0000);
    check(24'(busy), 24'h00_0001);
    i_master.start();
    i_master.send({ADDR, 1'b1}, ack);
    check(24'(ack), 24'h00_0000);
    i_master.stop();
    for (int k = 0; k < 5; k++) begin
      wait_idle();
      conv_sample = smps[k];
      i_master.start();
      i_master.send({ADDR, 1'b0}, ack);
      i_master.send({1'b0, cfgs[k]}, ack);
      check(24'(ack), 24'h00_0001);
      i_master.stop();
      check(24'({temp_sensor_on, gain_code, reject_sel, double_rate_on,
        calibration_on, gain_factor}), 24'({cfgs[k][3], cfgs[k][3] ?
        3'h0 : cfgs[k][6:4], cfgs[k][2:1], ~cfgs[k][3] & cfgs[k][0],
        cfgs[k][3] | ~cfgs[k][0], expg(cfgs[k])}));
      wait_idle();
      read3(expw(smps[k], 1'b1, cfgs[k]));
      i_master.stop();
    end
    wait_idle();
    i_master.start();
    i_master.send({ADDR, 1'b0}, ack);
    i_master.send(8'h00, ack);
    read3(24'h80_0030);
    i_master.stop();
    check(24'(gain_factor), 24'h00_0001);
    wait_idle();
    i_master.start();
    i_master.send({ADDR, 1'b1}, ack);
    i_master.recv(1'b0, b0);
    check(24'(b0), 24'h00_0080);
    i_master.stop();
    check(24'(busy), 24'h00_0001);
    wait_idle();
    conv_zero_polarity = 1'b0;
    i_master.start();
    i_master.send({adc_i2c_pkg::GLOBAL_ADDR, 1'b0}, ack);
    check(24'(ack), 24'h00_0001);
    i_master.stop();
    check(24'(busy), 24'h00_0001);
    wait_idle();
    read3(24'h00_0000);
    i_master.stop();
    print_verdict();
  end
endmodule
